// ### hdl/timer_pkg.sv
package timer_pkg;

  // channel and field sizes
  localparam int         CHANNELS      = 2;
  localparam int         COUNT_W       = 8;
  localparam int         FLAG_W        = 3;
  localparam int         FLAG_WRAP     = 0;
  localparam int         FLAG_A        = 1;
  localparam int         FLAG_B        = 2;

  // clock select codes
  localparam logic [2:0] CKS_STOP      = 3'h0;
  localparam logic [2:0] CKS_DIV8      = 3'h1;
  localparam logic [2:0] CKS_DIV64     = 3'h2;
  localparam logic [2:0] CKS_DIV8192   = 3'h3;
  localparam logic [2:0] CKS_CASCADE   = 3'h4;
  localparam logic [2:0] CKS_EXT_RISE  = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL  = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH  = 3'h7;

  // clear select codes {clear_select_hi, clear_select_lo}
  localparam logic [1:0] CLR_NONE      = 2'h0;
  localparam logic [1:0] CLR_MATCH_A   = 2'h1;
  localparam logic [1:0] CLR_MATCH_B   = 2'h2;
  localparam logic [1:0] CLR_EXT       = 2'h3;

  // output action codes, numeric order is priority order
  localparam logic [1:0] ACT_KEEP      = 2'h0;
  localparam logic [1:0] ACT_LOW       = 2'h1;
  localparam logic [1:0] ACT_HIGH      = 2'h2;
  localparam logic [1:0] ACT_TOGGLE    = 2'h3;

  // prescaler taps
  localparam int         PRESCALE_W    = 13;
  localparam int         TAP_DIV8      = 2;
  localparam int         TAP_DIV64     = 5;
  localparam int         TAP_DIV8192   = 12;

  // reset values
  localparam logic [12:0] PRESCALE_RESET = 13'h0000;
  localparam logic [7:0]  COUNT_RESET    = 8'h00;
  localparam logic [7:0]  COUNT_MAX      = 8'hff;
  localparam logic [7:0]  CONST_RESET    = 8'hff;
  localparam logic [2:0]  FLAGS_RESET    = 3'h0;
  localparam logic        WAVE_RESET     = 1'b0;

  // least pulse widths on the external pins, in picoseconds
  localparam int CLK_PERIOD_PS     = 8000;
  localparam int EXT_SINGLE_MIN_PS = 12000;
  localparam int EXT_BOTH_MIN_PS   = 20000;
  localparam int EXT_CLEAR_MIN_PS  = 12000;
  localparam int EXT_SINGLE_MIN_CYC = (EXT_SINGLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EXT_BOTH_MIN_CYC   = (EXT_BOTH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EXT_CLEAR_MIN_CYC  = (EXT_CLEAR_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {MODE_SPLIT, MODE_WIDE, MODE_CHAIN, MODE_HALT} cascade_mode_t;

endpackage

// ### hdl/prescale_taps.sv
`timescale 1ns/10ps
module prescale_taps (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  output logic      [2:0] taps
);

  logic [timer_pkg::PRESCALE_W-1:0] div_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_reg <= timer_pkg::PRESCALE_RESET;
    end else begin
      div_reg <= div_reg + 13'h0001;
    end
  end

  // tap levels; each falls once per its division period
  assign taps = {div_reg[timer_pkg::TAP_DIV8192], div_reg[timer_pkg::TAP_DIV64], div_reg[timer_pkg::TAP_DIV8]};

endmodule // prescale_taps

// ### hdl/count_source.sv
`timescale 1ns/10ps
module count_source (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] clock_select,
  input  wire logic [2:0] taps,
  input  wire logic       ext_clk,
  output logic            tick
);

  logic int_level;
  logic int_prev_reg;
  logic ext_prev_reg;
  logic ext_rise;
  logic ext_fall;

  assign int_level = (clock_select == timer_pkg::CKS_DIV8)    ? taps[0] :
                     (clock_select == timer_pkg::CKS_DIV64)   ? taps[1] :
                     (clock_select == timer_pkg::CKS_DIV8192) ? taps[2] : 1'b0;

  assign ext_rise = ext_clk & ~ext_prev_reg;
  assign ext_fall = ~ext_clk & ext_prev_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      int_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      int_prev_reg <= int_level;
      ext_prev_reg <= ext_clk;
    end
  end

  // falling edge of the selected tap, a select change high to low counts too
  assign tick = (int_prev_reg & ~int_level)
              | ((clock_select == timer_pkg::CKS_EXT_RISE) & ext_rise)
              | ((clock_select == timer_pkg::CKS_EXT_FALL) & ext_fall)
              | ((clock_select == timer_pkg::CKS_EXT_BOTH) & (ext_rise | ext_fall));

endmodule // count_source

// ### hdl/dual_8bit_compare_timer.sv
// What this block does
// - internal count sources are system clock divided by 8, 64 or 8192
// - external clock counts on rising, falling or both edges
// - match fires in the last equal state, on the next count clock
// - a match drives the output per its action: keep, low, high, toggle
// - action code 0110 gives high on match A, low on match B
// - counter clears on match A or B as the clear select chooses
// - external clear pin clears on its rising edge; pulse at least 1.5 states
// - wrap flag sets when counter goes from all ones to zero
// - channel 0 select 100 joins both channels into a 16-bit counter
// - 16-bit mode: channel 0 flags on full match, channel 1 on low byte
// - 16-bit mode: channel 0 clear field clears both bytes; channel 1 ignored
// - 16-bit mode: output 0 follows 16-bit matches, output 1 low-byte matches
// - channel 1 select 100 counts channel 0 match A events
// - both cascade modes together stop both counters
// - each channel raises match A, match B and wrap requests; wrap never transfers
// - conversion start pulses only on channel 0 match A with trigger enabled
// - clear in the counter write state wins and the write is lost
// - write in the same state as a count wins and the count is lost
// - a constant write suppresses that state's compare match
// - coinciding matches take the higher action: toggle, high, low, keep
// - internal pulses come from tap falling edges; select changes may add one
// - action high pair serves match B, low pair match A
// - flag clears by writing 0 after reading it as 1; writing 1 does nothing
// - outputs stay low after reset until the first match
`timescale 1ns/10ps
module dual_8bit_compare_timer (
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic [1:0][2:0] clock_select,
  input  wire logic [1:0]      clear_select_hi,
  input  wire logic [1:0]      clear_select_lo,
  input  wire logic [1:0][3:0] output_action,
  input  wire logic [1:0]      enable_match_a,
  input  wire logic [1:0]      enable_match_b,
  input  wire logic [1:0]      enable_wrap,
  input  wire logic            conv_trigger_enable,
  input  wire logic [1:0]      ext_clk_in,
  input  wire logic            ext_clear_in_ch0,
  input  wire logic            ext_clear_in_ch1,
  input  wire logic [1:0]      counter_wr,
  input  wire logic [1:0][7:0] counter_wdata,
  input  wire logic [1:0]      const_a_wr,
  input  wire logic [1:0]      const_b_wr,
  input  wire logic [1:0][7:0] const_wdata,
  input  wire logic [1:0]      flags_rd,
  input  wire logic [1:0]      flags_wr,
  input  wire logic [1:0][2:0] flags_wdata,
  output logic      [7:0]      up_counter_ch0,
  output logic      [7:0]      up_counter_ch1,
  output logic      [1:0][7:0] match_constant_a,
  output logic      [1:0][7:0] match_constant_b,
  output logic      [1:0]      match_flag_a,
  output logic      [1:0]      match_flag_b,
  output logic      [1:0]      wrap_flag,
  output logic                 wave_out_ch0,
  output logic                 wave_out_ch1,
  output logic      [1:0]      match_a_request,
  output logic      [1:0]      match_b_request,
  output logic      [1:0]      wrap_request,
  output logic      [1:0]      xfer_start_a,
  output logic      [1:0]      xfer_start_b,
  output logic                 conv_start
);

  // clear source decode, shared by both channels
  function automatic logic clear_hit(input logic [1:0] sel, input logic hit_a, input logic hit_b,
                                     input logic ext_edge);
    clear_hit = ((sel == timer_pkg::CLR_MATCH_A) & hit_a)
              | ((sel == timer_pkg::CLR_MATCH_B) & hit_b)
              | ((sel == timer_pkg::CLR_EXT) & ext_edge);
  endfunction

  // next output level; higher action code wins on coincidence
  function automatic logic apply_action(input logic cur, input logic [3:0] act, input logic hit_a,
                                        input logic hit_b);
    logic [1:0] code_a;
    logic [1:0] code_b;
    logic [1:0] code;
    code_a = hit_a ? act[1:0] : timer_pkg::ACT_KEEP;
    code_b = hit_b ? act[3:2] : timer_pkg::ACT_KEEP;
    code   = (code_a > code_b) ? code_a : code_b;
    case (code)
      timer_pkg::ACT_KEEP:   apply_action = cur;
      timer_pkg::ACT_LOW:    apply_action = 1'b0;
      timer_pkg::ACT_HIGH:   apply_action = 1'b1;
      timer_pkg::ACT_TOGGLE: apply_action = ~cur;
      default:               apply_action = cur;
    endcase
  endfunction

  wire logic [2:0]      taps;
  wire logic [1:0]      src_tick;
  wire logic [1:0]      ext_clear;
  wire logic [1:0]      ext_edge;
  wire logic [1:0]      tick;
  wire logic [1:0]      upd;
  wire logic [1:0]      eq_a;
  wire logic [1:0]      eq_b;
  wire logic [1:0]      ma;
  wire logic [1:0]      mb;
  wire logic [1:0]      clr;
  wire logic [1:0]      inc;
  wire logic [1:0]      wrap;
  wire logic [1:0][1:0] clr_sel;
  wire logic [1:0][7:0] cnt_q;
  wire logic            wide_sel;
  wire logic            chain_sel;
  wire logic            carry;
  timer_pkg::cascade_mode_t mode;
  logic                 conv_start_reg;

  prescale_taps u_taps (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .taps     (taps)
  );

  assign ext_clear = {ext_clear_in_ch1, ext_clear_in_ch0};

  // cascade mode
  assign wide_sel  = clock_select[0] == timer_pkg::CKS_CASCADE;
  assign chain_sel = clock_select[1] == timer_pkg::CKS_CASCADE;
  assign mode = (wide_sel & chain_sel) ? timer_pkg::MODE_HALT :
                wide_sel               ? timer_pkg::MODE_WIDE :
                chain_sel              ? timer_pkg::MODE_CHAIN :
                                         timer_pkg::MODE_SPLIT;

  // low byte carry into the high byte
  assign carry = src_tick[1] & (cnt_q[1] == timer_pkg::COUNT_MAX) & ~counter_wr[1];

  assign tick[1] = (mode == timer_pkg::MODE_HALT)  ? 1'b0 :
                   (mode == timer_pkg::MODE_CHAIN) ? ma[0] :
                                                     src_tick[1];
  assign tick[0] = (mode == timer_pkg::MODE_HALT) ? 1'b0 :
                   (mode == timer_pkg::MODE_WIDE) ? carry :
                                                    src_tick[0];

  // moment a match is taken: the count clock that ends the equal state
  assign upd[0] = (mode == timer_pkg::MODE_WIDE) ? src_tick[1] : tick[0];
  assign upd[1] = tick[1];

  // channel 0 matches are 16-bit wide in 16-bit mode
  assign ma[0] = upd[0] & eq_a[0] & ~const_a_wr[0]
               & ((mode != timer_pkg::MODE_WIDE) | (eq_a[1] & ~const_a_wr[1]));
  assign mb[0] = upd[0] & eq_b[0] & ~const_b_wr[0]
               & ((mode != timer_pkg::MODE_WIDE) | (eq_b[1] & ~const_b_wr[1]));
  assign ma[1] = upd[1] & eq_a[1] & ~const_a_wr[1];
  assign mb[1] = upd[1] & eq_b[1] & ~const_b_wr[1];

  assign clr[0] = clear_hit(clr_sel[0], ma[0], mb[0], ext_edge[0]);
  assign clr[1] = (mode == timer_pkg::MODE_WIDE) ? clr[0]
                                                 : clear_hit(clr_sel[1], ma[1], mb[1], ext_edge[1]);

  genvar i;
  generate
    for (i = 0; i < timer_pkg::CHANNELS; i = i + 1) begin : g_ch
      logic [7:0] cnt_reg;
      logic [7:0] cnt_next;
      logic [7:0] const_a_reg;
      logic [7:0] const_b_reg;
      logic [2:0] flag_reg;
      logic [2:0] flag_next;
      logic [2:0] armed_reg;
      logic [2:0] armed_next;
      logic [2:0] set_vec;
      logic [2:0] clear_vec;
      logic       wave_reg;
      logic       wave_next;
      logic       ext_prev_reg;
      logic       req_a_reg;
      logic       req_b_reg;
      logic       req_w_reg;
      logic       xfer_a_reg;
      logic       xfer_b_reg;

      count_source u_src (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .clock_select (clock_select[i]),
        .taps         (taps),
        .ext_clk      (ext_clk_in[i]),
        .tick         (src_tick[i])
      );

      assign clr_sel[i]  = {clear_select_hi[i], clear_select_lo[i]};
      assign ext_edge[i] = ext_clear[i] & ~ext_prev_reg;
      assign eq_a[i]     = cnt_reg == const_a_reg;
      assign eq_b[i]     = cnt_reg == const_b_reg;
      assign cnt_q[i]    = cnt_reg;

      // clear beats write, write beats count
      assign inc[i]   = tick[i] & ~clr[i] & ~counter_wr[i];
      assign wrap[i]  = inc[i] & (cnt_reg == timer_pkg::COUNT_MAX);
      assign cnt_next = clr[i]        ? timer_pkg::COUNT_RESET :
                        counter_wr[i] ? counter_wdata[i] :
                        inc[i]        ? cnt_reg + 8'h01 : cnt_reg;

      // flags: clear needs a prior read of 1, a set in the same cycle wins
      assign set_vec[timer_pkg::FLAG_WRAP] = wrap[i];
      assign set_vec[timer_pkg::FLAG_A]    = ma[i];
      assign set_vec[timer_pkg::FLAG_B]    = mb[i];
      assign clear_vec  = flags_wr[i] ? (armed_reg & ~flags_wdata[i]) : timer_pkg::FLAGS_RESET;
      assign flag_next  = (flag_reg & ~clear_vec) | set_vec;
      assign armed_next = flags_rd[i] ? flag_reg :
                          flags_wr[i] ? timer_pkg::FLAGS_RESET : armed_reg;

      assign wave_next = apply_action(wave_reg, output_action[i], ma[i], mb[i]);

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          cnt_reg      <= timer_pkg::COUNT_RESET;
          const_a_reg  <= timer_pkg::CONST_RESET;
          const_b_reg  <= timer_pkg::CONST_RESET;
          flag_reg     <= timer_pkg::FLAGS_RESET;
          armed_reg    <= timer_pkg::FLAGS_RESET;
          wave_reg     <= timer_pkg::WAVE_RESET;
          ext_prev_reg <= 1'b0;
          req_a_reg    <= 1'b0;
          req_b_reg    <= 1'b0;
          req_w_reg    <= 1'b0;
          xfer_a_reg   <= 1'b0;
          xfer_b_reg   <= 1'b0;
        end else begin
          cnt_reg      <= cnt_next;
          if (const_a_wr[i]) begin
            const_a_reg <= const_wdata[i];
          end
          if (const_b_wr[i]) begin
            const_b_reg <= const_wdata[i];
          end
          flag_reg     <= flag_next;
          armed_reg    <= armed_next;
          wave_reg     <= wave_next;
          ext_prev_reg <= ext_clear[i];
          req_a_reg    <= flag_next[timer_pkg::FLAG_A] & enable_match_a[i];
          req_b_reg    <= flag_next[timer_pkg::FLAG_B] & enable_match_b[i];
          req_w_reg    <= flag_next[timer_pkg::FLAG_WRAP] & enable_wrap[i];
          xfer_a_reg   <= flag_next[timer_pkg::FLAG_A] & enable_match_a[i];
          xfer_b_reg   <= flag_next[timer_pkg::FLAG_B] & enable_match_b[i];
        end
      end

      assign match_constant_a[i] = const_a_reg;
      assign match_constant_b[i] = const_b_reg;
      assign match_flag_a[i]     = flag_reg[timer_pkg::FLAG_A];
      assign match_flag_b[i]     = flag_reg[timer_pkg::FLAG_B];
      assign wrap_flag[i]        = flag_reg[timer_pkg::FLAG_WRAP];
      assign match_a_request[i]  = req_a_reg;
      assign match_b_request[i]  = req_b_reg;
      assign wrap_request[i]     = req_w_reg;
      assign xfer_start_a[i]     = xfer_a_reg;
      assign xfer_start_b[i]     = xfer_b_reg;
    end
  endgenerate

  // conversion start, one cycle after channel 0 match A
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_start_reg <= 1'b0;
    end else begin
      conv_start_reg <= ma[0] & conv_trigger_enable;
    end
  end

  assign conv_start     = conv_start_reg;
  assign up_counter_ch0 = g_ch[0].cnt_reg;
  assign up_counter_ch1 = g_ch[1].cnt_reg;
  assign wave_out_ch0   = g_ch[0].wave_reg;
  assign wave_out_ch1   = g_ch[1].wave_reg;

endmodule // dual_8bit_compare_timer

// ### dv/dual_8bit_compare_timer_assertions.sv
`timescale 1ns/10ps
module timer_checker (
  input wire logic            core_clk,
  input wire logic            rst_n,
  input wire logic [1:0][2:0] clock_select,
  input wire logic [1:0]      clear_select_hi,
  input wire logic [1:0]      clear_select_lo,
  input wire logic [1:0][3:0] output_action,
  input wire logic            conv_trigger_enable,
  input wire logic [1:0]      counter_wr,
  input wire logic [1:0]      const_a_wr,
  input wire logic [1:0]      flags_wr,
  input wire logic [1:0][2:0] flags_wdata,
  input wire logic [7:0]      up_counter_ch0,
  input wire logic [7:0]      up_counter_ch1,
  input wire logic [1:0][7:0] match_constant_a,
  input wire logic [1:0]      match_flag_a,
  input wire logic [1:0]      wrap_flag,
  input wire logic            wave_out_ch0,
  input wire logic            wave_out_ch1,
  input wire logic            conv_start
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_reset_state;
    $rose(rst_n) |-> !wave_out_ch0 && !wave_out_ch1 && up_counter_ch0 == 8'h00 && match_flag_a == 2'h0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("outputs not idle after reset");
  property p_conv_pulse;
    conv_start |-> match_flag_a[0] && $past(conv_trigger_enable) ##1 !conv_start;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("conversion start pulse wrong");
  property p_wrap_set;
    $rose(wrap_flag[1]) |-> up_counter_ch1 == 8'h00 && $past(up_counter_ch1) == 8'hff;
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wrap flag without wrap");
  property p_match_late;
    $rose(match_flag_a[1]) && $past(clock_select[1]) inside {3'h1, 3'h2, 3'h3} && !$past(clear_select_hi[1])
      && !$past(clear_select_lo[1]) && !$past(counter_wr[1])
      |-> up_counter_ch1 == 8'($past(match_constant_a[1]) + 8'h01);
  endproperty
  a_match_late: assert property (p_match_late) else $error("match flag at wrong count");
  property p_clear_a;
    $rose(match_flag_a[0]) && $past(clock_select[0]) inside {3'h1, 3'h2, 3'h3} && !$past(clear_select_hi[0])
      && $past(clear_select_lo[0]) && !$past(counter_wr[0]) |-> up_counter_ch0 == 8'h00;
  endproperty
  a_clear_a: assert property (p_clear_a) else $error("counter not cleared on match");
  property p_pulse_high;
    $rose(match_flag_a[0]) && $past(output_action[0]) == 4'h6 |-> wave_out_ch0;
  endproperty
  a_pulse_high: assert property (p_pulse_high) else $error("wave not high on match");
  property p_const_block;
    $past(const_a_wr[0]) && !$past(match_flag_a[0]) |-> !match_flag_a[0];
  endproperty
  a_const_block: assert property (p_const_block) else $error("match during constant write");
  property p_write_one;
    $past(flags_wr[0]) && $past(flags_wdata[0][1]) && $past(match_flag_a[0]) |-> match_flag_a[0];
  endproperty
  a_write_one: assert property (p_write_one) else $error("flag cleared by writing one");
endmodule // timer_checker

bind dual_8bit_compare_timer timer_checker chk_u (
  .core_clk, .rst_n, .clock_select, .clear_select_hi, .clear_select_lo, .output_action,
  .conv_trigger_enable, .counter_wr, .const_a_wr, .flags_wr, .flags_wdata, .up_counter_ch0,
  .up_counter_ch1, .match_constant_a, .match_flag_a, .wrap_flag, .wave_out_ch0, .wave_out_ch1, .conv_start
);

// ### dv/ext_pin_model.sv
`timescale 1ns/10ps
module ext_pin_model #(
  parameter int HOLD = 3
) (
  input  wire logic       core_clk,
  input  wire logic [1:0] run_clk,
  input  wire logic       clear_req,
  output logic      [1:0] ext_clk,
  output logic            ext_clear
);
  int hold_cnt = 0;
  int clr_cnt = 0;
  initial ext_clk = 2'h0;
  initial ext_clear = 1'b0;
  // levels held HOLD cycles, still when not running
  always @(posedge core_clk) begin
    hold_cnt <= (hold_cnt + 1) % HOLD;
    if (hold_cnt == 0) ext_clk <= #1 ext_clk ^ run_clk;
    clr_cnt <= clear_req ? 4 : (clr_cnt > 0 ? clr_cnt - 1 : 0);
    ext_clear <= #1 (clr_cnt > 2);
  end
endmodule // ext_pin_model

// ### dv/tb_dual_8bit_compare_timer.sv
`timescale 1ns/10ps
module tb_dual_8bit_compare_timer;
  logic            core_clk, rst_n, conv_trigger_enable, conv_start, clear_req, ext_clear, wave_out_ch0, wave_out_ch1;
  logic [1:0][2:0] clock_select, flags_wdata;
  logic [1:0][3:0] output_action;
  logic [1:0][7:0] counter_wdata, const_wdata, match_constant_a, match_constant_b;
  logic [1:0]      clear_select_hi, clear_select_lo, enable_match_a, enable_match_b, enable_wrap, run_clk, ext_clk;
  logic [1:0]      counter_wr, const_a_wr, const_b_wr, flags_rd, flags_wr, match_flag_a, match_flag_b, wrap_flag;
  logic [1:0]      match_a_request, match_b_request, wrap_request, xfer_start_a, xfer_start_b;
  logic [7:0]      up_counter_ch0, up_counter_ch1, n_cnt, m_cnt, rnd;
  logic            ext_prev = 1'b0;
  integer          seed = 3;
  int              n_fail = 0, checks_done = 0, rises = 0, falls = 0, conv_cnt = 0, r0, f0, exp_n;
  int              ext_modes[$] = '{5, 6, 7};

  dual_8bit_compare_timer dut_u (
    .core_clk, .rst_n, .clock_select, .clear_select_hi, .clear_select_lo, .output_action, .enable_match_a,
    .enable_match_b, .enable_wrap, .conv_trigger_enable, .ext_clk_in(ext_clk), .ext_clear_in_ch0(ext_clear),
    .ext_clear_in_ch1(ext_clear), .counter_wr, .counter_wdata, .const_a_wr, .const_b_wr, .const_wdata, .flags_rd,
    .flags_wr, .flags_wdata, .up_counter_ch0, .up_counter_ch1, .match_constant_a, .match_constant_b,
    .match_flag_a, .match_flag_b, .wrap_flag, .wave_out_ch0, .wave_out_ch1, .match_a_request,
    .match_b_request, .wrap_request, .xfer_start_a, .xfer_start_b, .conv_start
  );
  ext_pin_model pin_u (.core_clk, .run_clk, .clear_req, .ext_clk, .ext_clear);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // edge tallies of the model and tally of conv_start pulses
  always @(posedge core_clk) begin
    ext_prev <= ext_clk[1];
    if (ext_clk[1] && !ext_prev) rises <= rises + 1;
    if (!ext_clk[1] && ext_prev) falls <= falls + 1;
    if (conv_start === 1'b1) conv_cnt <= conv_cnt + 1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic cond(input int sel);
    case (sel)
      0: cond = match_flag_a[0];
      1: cond = match_flag_b[0];
      2: cond = wrap_flag[1];
      3: cond = (up_counter_ch1 == 8'h00);
      default: cond = (up_counter_ch1 == 8'h03);
    endcase
  endfunction

  task automatic wait_for(input int sel, input int limit);
    int i;
    i = 0;
    while (cond(sel) !== 1'b1 && i < limit) begin
      step(1);
      i++;
    end
    if (i >= limit) begin
      n_fail++;
      $display("[ERR] wait %0d expected 1 seen 0", sel);
      tally_and_finish();
    end
  endtask

  task automatic wr_cnt(input logic [1:0] sel, input logic [7:0] d0, input logic [7:0] d1);
    counter_wdata = {d1, d0};
    counter_wr = sel;
    step(1);
    counter_wr = 2'h0;
  endtask

  task automatic wr_const(input int ch, input logic b, input logic [7:0] d);
    const_wdata[ch] = d;
    const_a_wr[ch] = !b;
    const_b_wr[ch] = b;
    step(1);
    const_a_wr = 2'h0;
    const_b_wr = 2'h0;
    step(1);
  endtask

  task automatic flag_op(input logic rd, input logic [2:0] d);
    flags_rd[0] = rd;
    step(1);
    flags_rd[0] = 1'b0;
    flags_wdata[0] = d;
    flags_wr[0] = 1'b1;
    step(1);
    flags_wr[0] = 1'b0;
    step(1);
  endtask

  initial begin
    rst_n = 1'b0;
    {clock_select, flags_wdata, output_action, counter_wdata, const_wdata} = '0;
    {clear_select_hi, clear_select_lo, enable_match_a, enable_match_b, enable_wrap} = '0;
    {counter_wr, const_a_wr, const_b_wr, flags_rd, flags_wr, run_clk} = '0;
    conv_trigger_enable = 1'b0;
    clear_req = 1'b0;
    step(3);
    rst_n = 1'b1;
    chk("cnt0", 8'h00, up_counter_ch0);
    chk("const_a1", 8'hff, match_constant_a[1]);
    chk("waves", 8'h00, {6'h0, wave_out_ch1, wave_out_ch0});
    // pulse train on channel 0
    n_cnt = 8'h04 + 8'($random(seed) & 7);
    m_cnt = n_cnt >> 1;
    wr_const(0, 1'b0, n_cnt);
    wr_const(0, 1'b1, m_cnt);
    chk("const_b0", m_cnt, match_constant_b[0]);
    wr_cnt(2'h1, 8'h00, 8'h00);
    clear_select_lo[0] = 1'b1;
    output_action[0] = 4'h6;
    {enable_match_a, enable_match_b, enable_wrap} = 6'h3f;
    conv_trigger_enable = 1'b1;
    clock_select[0] = timer_pkg::CKS_DIV8;
    wait_for(0, 400);
    chk("cnt0", 8'h00, up_counter_ch0);
    chk("wave0", 8'h01, {7'h0, wave_out_ch0});
    chk("xfer_a0", 8'h01, {7'h0, xfer_start_a[0]});
    chk("req_a0", 8'h01, {7'h0, match_a_request[0]});
    step(1);
    chk("conv", 8'h01, 8'(conv_cnt));
    flag_op(1'b1, 3'h7);
    flag_op(1'b0, 3'h0);
    chk("flag_a0", 8'h01, {7'h0, match_flag_a[0]});
    flag_op(1'b1, 3'h0);
    chk("flag_a0", 8'h00, {7'h0, match_flag_a[0]});
    wait_for(1, 400);
    chk("cnt0", m_cnt + 8'h01, up_counter_ch0);
    chk("wave0", 8'h00, {7'h0, wave_out_ch0});
    chk("req_xfer_b0", 8'h03, {6'h0, match_b_request[0], xfer_start_b[0]});
    // wrap on channel 1, match a toggles its output
    output_action[1] = 4'h3;
    clock_select[1] = timer_pkg::CKS_DIV8;
    wr_cnt(2'h2, 8'h00, 8'hfd);
    wait_for(2, 64);
    step(1);
    chk("cnt1", 8'h00, up_counter_ch1);
    chk("wrap_req1", 8'h01, {7'h0, wrap_request[1]});
    chk("wave1", 8'h01, {7'h0, wave_out_ch1});
    // joined 16-bit count
    clock_select[0] = timer_pkg::CKS_CASCADE;
    wr_cnt(2'h3, 8'h12, 8'hfe);
    wait_for(3, 64);
    chk("cnt0", 8'h13, up_counter_ch0);
    // both cascade modes halt
    clock_select = {timer_pkg::CKS_CASCADE, timer_pkg::CKS_CASCADE};
    rnd = 8'($random(seed));
    wr_cnt(2'h3, rnd, ~rnd);
    step(40);
    chk("cnt0", rnd, up_counter_ch0);
    chk("cnt1", ~rnd, up_counter_ch1);
    // channel 1 counts channel 0 match a
    wr_const(0, 1'b0, 8'h03);
    wr_cnt(2'h3, 8'h00, 8'h00);
    clock_select = {timer_pkg::CKS_CASCADE, timer_pkg::CKS_DIV8};
    wait_for(4, 400);
    chk("cnt0", 8'h00, up_counter_ch0);
    // external clock edge modes
    clock_select[0] = timer_pkg::CKS_STOP;
    foreach (ext_modes[i]) begin
      clock_select[1] = 3'(ext_modes[i]);
      step(2);
      wr_cnt(2'h2, 8'h00, 8'h00);
      r0 = rises;
      f0 = falls;
      run_clk = 2'h2;
      step(30);
      run_clk = 2'h0;
      step(6);
      exp_n = (ext_modes[i] != 6 ? rises - r0 : 0) + (ext_modes[i] != 5 ? falls - f0 : 0);
      chk("cnt1", 8'(exp_n), up_counter_ch1);
    end
    // external clear pin on both channels
    {clear_select_hi[0], clear_select_lo[0]} = timer_pkg::CLR_EXT;
    {clear_select_hi[1], clear_select_lo[1]} = timer_pkg::CLR_EXT;
    wr_cnt(2'h3, 8'h40, 8'h40);
    clear_req = 1'b1;
    step(1);
    clear_req = 1'b0;
    step(6);
    chk("cnt0", 8'h00, up_counter_ch0);
    chk("cnt1", 8'h00, up_counter_ch1);
    tally_and_finish();
  end
endmodule // tb_dual_8bit_compare_timer
